// >>> rtl/gate_driver_fault_monitor.sv
// Purpose: Fault supervision for a three-phase gate driver with registers.
// Assumes: Comparator inputs are asynchronous; all other inputs are
//          synchronous to aclk.
// Notes:   Logic-supply undervolt acts as an internal power-on reset.
`timescale 1ns/100ps

// Notes on behaviour
// - A masked diagnostic makes no fault state, pin change or word bit.
// - Logic and gate-supply undervoltage can never be masked.
// - Any chip-level fault present pulls the fault pin low.
// - Temperature warning pulls pin low, sets bits 11 and 15 only.
// - Warning clear releases pin; its word bits stay until reset.
// - Overtemperature pulls pin low and sets bits 10 and 15.
// - Overtemperature disables all gates only when stop-on-fault is 1.
// - Overtemperature clear releases pin; word bits stay until cleared.
// - Gate-supply undervolt: pin low, bits 13 and 15, gates low.
// - Gate-supply recovery re-enables gates and releases the pin.
// - At power-up pin and gates stay low until gate supply good, except for the two cycles after aresetn rises.
// - Logic-supply undervolt disables outputs and suspends activity.
// - Recovery resets registers, clears faults, sets bits 15 and 14.
// - Same reset sequence for power-up and any brown-out.
// - Low bootstrap: charge via low side before enabling high side.
// - Bootstrap dropping while high side is on restarts a charge.
// - Charge timeout: pin low, outputs off, per-phase bit set.
// - Bootstrap fault held until reset input, word read or POR.
// - Flag a MOSFET fault when drain-source exceeds the threshold.
// - Threshold code is six bits driving a 25 mV step converter.
// - Bit 15 is set whenever any other fault word bit is set.
// - A completed register write resets the fault word.
// - Drain-source sampled only after blanking count times 400 ns.
module gate_driver_fault_monitor
  import fault_mon_pkg::*;
#(
  parameter int BOOT_TO_CYC = BOOT_TIMEOUT_CYC
)
(
  // Clock, reset and clock enable.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Analog comparator results, asynchronous.
  input  wire logic                 temp_warn_raw,
  input  wire logic                 overtemp_raw,
  input  wire logic                 gate_supply_uv_raw,
  input  wire logic                 logic_uv_raw,
  input  wire logic [NPH-1:0]       boot_ok_raw,
  input  wire logic [2*NPH-1:0]     vds_high_raw,
  // Gate drive requests and outputs.
  input  wire logic [NPH-1:0]       hs_req,
  input  wire logic [NPH-1:0]       ls_req,
  output logic [NPH-1:0]            hs_gate,
  output logic [NPH-1:0]            ls_gate,
  // Pins.
  input  wire logic                 active_low_reset_input,
  output logic                      fault_output_pin_n,
  output logic [THRESH_W-1:0]       drain_source_threshold_code
);

  localparam int SYNC_W     = 4 + NPH + 2 * NPH;
  localparam int BOOT_CNT_W = $clog2(BOOT_TO_CYC + 1);

  // Merges a bus write into a 16-bit register by byte strobe.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Blanking interval in clock cycles for a given count.
  function automatic logic [8:0] blank_target(input logic [3:0] n);
    blank_target = 9'(int'(n) * BLANK_UNIT_CYC);
  endfunction

  logic [SYNC_W-1:0]       sync1_r;
  logic [SYNC_W-1:0]       sync2_r;
  logic                    warn_s;
  logic                    otemp_s;
  logic                    gate_supply_uv_s;
  logic                    logic_uv_s;
  logic [NPH-1:0]          boot_ok_s;
  logic [2*NPH-1:0]        vds_s;
  logic [15:0]             run_r;
  logic [15:0]             cfg0_r;
  logic [15:0]             cfg1_r;
  logic [15:0]             mask_r;
  logic [15:0]             fault_word_r;
  logic [15:0]             fault_word_nxt;
  logic [15:0]             fault_evt;
  logic [14:0]             fault_low;
  logic [NPH-1:0]          boot_lat_r;
  logic [NPH-1:0]          boot_lat_nxt;
  logic [2*NPH-1:0]        short_lat_r;
  logic [2*NPH-1:0]        short_lat_nxt;
  logic [NPH-1:0]          boot_tmo;
  logic [NPH-1:0]          charging;
  logic [NPH-1:0]          hs_ready;
  logic [2*NPH-1:0]        vds_now;
  logic [8:0]              blank_cnt_r [2*NPH];
  logic [8:0]              blank_lim;
  logic                    stop_en;
  logic                    warn_m;
  logic                    otemp_m;
  logic                    fault_now;
  logic                    drive_off;
  logic                    clr_lat;
  logic                    por;
  logic [ADDR_W-1:0]       aw_r;
  logic                    aw_have_r;
  logic [31:0]             wd_r;
  logic [3:0]              ws_r;
  logic                    w_have_r;
  logic                    bvalid_r;
  logic [1:0]              bresp_r;
  logic                    rvalid_r;
  logic [1:0]              rresp_r;
  logic [31:0]             rdata_r;
  logic                    wr_go;
  logic                    wr_hit;
  logic                    wr_ok;
  logic                    wr_err;
  logic                    ar_hs;
  logic                    rd_hit;
  logic                    word_read;
  logic [15:0]             rd_val;
  logic [15:0]             live_val;
  logic [NPH-1:0]          hs_gate_r;
  logic [NPH-1:0]          ls_gate_r;
  logic                    pin_r;

  // comparator synchronisers
  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else if (ce)
    begin
      sync1_r <= {temp_warn_raw, overtemp_raw, gate_supply_uv_raw,
                  logic_uv_raw, boot_ok_raw, vds_high_raw};
      sync2_r <= sync1_r;
    end
  end

  // Unpack the synchronised comparator vector.
  assign {warn_s, otemp_s, gate_supply_uv_s, logic_uv_s,
          boot_ok_s, vds_s} = sync2_r;

  assign warn_m  = warn_s & ~mask_r[TEMP_WARN_BIT];
  assign otemp_m = otemp_s & ~mask_r[OVERTEMP_BIT];

  // Control fields seen by the fault logic and the threshold converter.
  assign stop_en   = run_r[STOP_ON_FAULT_POS];
  assign blank_lim = blank_target(cfg0_r[BLANK_LSB +: BLANK_W]);
  assign drain_source_threshold_code = cfg1_r[THRESH_LSB +: THRESH_W];

  assign por = logic_uv_s;

  // gate drive off
  // Any of these forces every gate low and resets the bootstrap sequencers.
  assign drive_off = por | gate_supply_uv_s | (otemp_m & stop_en) |
                     (|boot_lat_r) | (|short_lat_r) |
                     ~active_low_reset_input;

  assign fault_now = warn_m | otemp_m | gate_supply_uv_s | por |
                     (|boot_lat_r) | (|vds_now) | (|short_lat_r);

  // fixed charge timeout
  // One sequencer per phase; the comparator carries its own hysteresis.
  for (genvar g = 0; g < NPH; g++)
  begin : g_ph
    boot_st_t              st_r;
    boot_st_t              st_nxt;
    logic [BOOT_CNT_W-1:0] cnt_r;
    logic                  want;
    logic                  ok;
    logic                  tmo;

    assign want = hs_req[g] & ~drive_off;
    assign ok   = boot_ok_s[g] | mask_r[BOOT_LSB+g];
    assign tmo  = (st_r == BS_CHARGE) & ~ok &
                  (cnt_r == BOOT_CNT_W'(BOOT_TO_CYC - 1));

    // Next state of the charge sequencer.
    always_comb
    begin
      st_nxt = st_r;
      case (st_r)
        BS_IDLE:
          if (want)
            st_nxt = ok ? BS_ON : BS_CHARGE;
        BS_CHARGE:
          if (!want || tmo)
            st_nxt = BS_IDLE;
          else if (ok)
            st_nxt = BS_ON;
        BS_ON:
          if (!want)
            st_nxt = BS_IDLE;
          else if (!ok)
            st_nxt = BS_CHARGE;
        default:
          st_nxt = BS_IDLE;
      endcase
    end

    // State and charge-time counter.
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        st_r  <= BS_IDLE;
        cnt_r <= '0;
      end
      else if (ce)
      begin
        st_r  <= st_nxt;
        cnt_r <= (st_r == BS_CHARGE && st_nxt == BS_CHARGE) ?
                 cnt_r + 1'b1 : '0;
      end
    end

    assign boot_tmo[g] = tmo;
    assign charging[g] = (st_r == BS_CHARGE);
    assign hs_ready[g] = (st_r == BS_ON);
  end

  // drain-source fault flag
  // Each gate has its own timer that restarts whenever the gate is off.
  for (genvar i = 0; i < 2 * NPH; i++)
  begin : g_vds
    logic on;

    assign on = (i < NPH) ? hs_gate_r[i % NPH] : ls_gate_r[i % NPH];

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        blank_cnt_r[i] <= '0;
      else if (ce)
        blank_cnt_r[i] <= !on ? '0 :
                          (blank_cnt_r[i] == blank_lim) ? blank_cnt_r[i] :
                          blank_cnt_r[i] + 1'b1;
    end

    assign vds_now[i] = on & (blank_cnt_r[i] == blank_lim) & vds_s[i] &
                        ~mask_r[SHORT_LSB+i];
  end

  // Fault word event vector; masked terms never reach it.
  always_comb
  begin
    fault_evt                            = '0;
    fault_evt[REG_UV_BIT]                = gate_supply_uv_s;
    fault_evt[TEMP_WARN_BIT]             = warn_m;
    fault_evt[OVERTEMP_BIT]              = otemp_m;
    fault_evt[BOOT_LSB +: NPH]           = boot_tmo;
    fault_evt[SHORT_LSB +: 2*NPH]        = vds_now;
  end

  // common flag follows
  // New events are merged after the clear, so a set wins over a reset.
  assign fault_low = (wr_ok ? 15'h0000 : fault_word_r[14:0]) |
                     fault_evt[14:0];
  assign fault_word_nxt = {(|fault_low) | wr_err |
                           (fault_word_r[COMMON_FAULT_BIT] & ~wr_ok),
                           fault_low};

  // charge timeout and short latches
  // Short faults latch only with stop-on-fault set and also clear on reset.
  assign clr_lat       = ~active_low_reset_input | word_read;
  assign boot_lat_nxt  = boot_tmo | (clr_lat ? '0 : boot_lat_r);
  assign short_lat_nxt = (vds_now & {2*NPH{stop_en}}) |
                         ((clr_lat | wr_ok) ? '0 : short_lat_r);

  // same sequence always
  // Registers are held at defaults for as long as the logic supply is low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (ce && por))
    begin
      run_r        <= RUN_RST;
      cfg0_r       <= CFG0_RST;
      cfg1_r       <= CFG1_RST;
      mask_r       <= MASK_RST;
      fault_word_r <= FAULT_POR_VAL;
      boot_lat_r   <= '0;
      short_lat_r  <= '0;
    end
    else if (ce)
    begin
      fault_word_r <= fault_word_nxt;
      boot_lat_r   <= boot_lat_nxt;
      short_lat_r  <= short_lat_nxt;
      if (wr_ok && aw_r == RUN_OFS)
        run_r <= merge(run_r, wd_r, ws_r);
      if (wr_ok && aw_r == CFG0_OFS)
        cfg0_r <= merge(cfg0_r, wd_r, ws_r);
      if (wr_ok && aw_r == CFG1_OFS)
        cfg1_r <= merge(cfg1_r, wd_r, ws_r);
      if (wr_ok && aw_r == MASK_OFS)
        mask_r <= merge(mask_r, wd_r, ws_r);
    end
  end

  // power-up hold
  // Gates and the pin are registered so they never glitch at the pins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_gate_r <= '0;
      ls_gate_r <= '0;
      pin_r     <= 1'b0;
    end
    else if (ce)
    begin
      hs_gate_r <= drive_off ? '0 : (hs_ready & hs_req);
      ls_gate_r <= drive_off ? '0 : (ls_req | charging);
      pin_r     <= ~fault_now;
    end
  end

  assign hs_gate            = hs_gate_r;
  assign ls_gate            = ls_gate_r;
  assign fault_output_pin_n = pin_r;

  // Write path: address and data are taken in either order.
  assign awready = ce & ~aw_have_r & ~bvalid_r;
  assign wready  = ce & ~w_have_r & ~bvalid_r;
  assign wr_go   = ce & aw_have_r & w_have_r & ~bvalid_r;
  assign wr_hit  = (aw_r == RUN_OFS) | (aw_r == CFG0_OFS) |
                   (aw_r == CFG1_OFS) | (aw_r == MASK_OFS) |
                   (aw_r == FAULT_WORD_OFS);
  assign wr_ok   = wr_go & wr_hit;
  assign wr_err  = wr_go & ~wr_hit;

  // Write channel state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_r      <= '0;
      aw_have_r <= 1'b0;
      wd_r      <= '0;
      ws_r      <= '0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_r      <= awaddr;
        aw_have_r <= 1'b1;
      end
      if (wvalid && wready)
      begin
        wd_r     <= wdata;
        ws_r     <= wstrb;
        w_have_r <= 1'b1;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;

  // Read decode; a read of the fault word clears the latched faults.
  assign arready   = ce & ~rvalid_r;
  assign ar_hs     = arvalid & arready;
  assign word_read = ar_hs & (araddr == FAULT_WORD_OFS);
  assign rd_hit    = (araddr == RUN_OFS) | (araddr == CFG0_OFS) |
                     (araddr == CFG1_OFS) | (araddr == MASK_OFS) |
                     (araddr == FAULT_WORD_OFS) | (araddr == LIVE_OFS);
  assign live_val  = {2'b00, short_lat_r, boot_lat_r, drive_off,
                      fault_now, gate_supply_uv_s, otemp_m, warn_m};
  assign rd_val    = (araddr == RUN_OFS)        ? run_r :
                     (araddr == CFG0_OFS)       ? cfg0_r :
                     (araddr == CFG1_OFS)       ? cfg1_r :
                     (araddr == MASK_OFS)       ? mask_r :
                     (araddr == FAULT_WORD_OFS) ? fault_word_r :
                     (araddr == LIVE_OFS)       ? live_val : 16'h0000;

  // Read channel state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= {16'h0000, rd_val};
      end
      else if (rvalid_r && rready)
        rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;

  // Checks on the fault behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_mask_blocks_warn: assert property (
    $rose(fault_word_r[TEMP_WARN_BIT]) |-> $past(!mask_r[TEMP_WARN_BIT]))
    else $error("Masked warning set its fault bit.");
  chk_supply_uv_off: assert property (
    (gate_supply_uv_s && ce) |=> (hs_gate == '0 && ls_gate == '0 &&
                                  !fault_output_pin_n))
    else $error("Gate supply undervolt left gates or pin active.");
  chk_pin_follows_fault: assert property (
    (ce && fault_now) |=> !fault_output_pin_n)
    else $error("Fault present but pin released.");
  chk_warn_bit_sticky: assert property (
    (ce && fault_word_r[TEMP_WARN_BIT] && !wr_ok && !por)
      |=> fault_word_r[TEMP_WARN_BIT])
    else $error("Warning bit lost without a word reset.");
  chk_overtemp_stop: assert property (
    (ce && otemp_m && stop_en) |=> (hs_gate == '0 && ls_gate == '0))
    else $error("Overtemperature with stop enable left gates on.");
  chk_common_flag: assert property (
    (|fault_word_r[14:0]) |-> fault_word_r[COMMON_FAULT_BIT])
    else $error("Fault bit set without the common flag.");
  chk_write_resets_word: assert property (
    (ce && wr_ok && !por && fault_evt == '0) |=> fault_word_r == '0)
    else $error("Completed write did not reset the fault word.");
  chk_por_word_value: assert property (
    (ce && por) |=> (fault_word_r == FAULT_POR_VAL && run_r == RUN_RST))
    else $error("Power-on reset values wrong.");
  chk_boot_latch_off: assert property (
    (ce && (|boot_lat_r)) |=> (hs_gate == '0 && ls_gate == '0 &&
                               !fault_output_pin_n))
    else $error("Bootstrap fault left outputs on.");

  cov_warn_event: cover property ($rose(fault_word_r[TEMP_WARN_BIT]));
  cov_boot_timeout: cover property (|boot_tmo);
  cov_por_recovery: cover property (por ##1 !por);
  cov_short_latched: cover property ($rose(|short_lat_r));
endmodule

// >>> rtl/fault_mon_pkg.sv
// Purpose: Shared constants and types for the gate-driver fault monitor.
// Assumes: 50 MHz system clock and a 32-bit AXI4-Lite register bus.
// Notes:   Offsets are byte addresses; registers hold 16 bits.
package fault_mon_pkg;
  localparam int ADDR_W = 8;
  localparam int NPH    = 3;

  // Register byte offsets.
  localparam logic [7:0] RUN_OFS        = 8'h00;
  localparam logic [7:0] CFG0_OFS       = 8'h04;
  localparam logic [7:0] CFG1_OFS       = 8'h08;
  localparam logic [7:0] MASK_OFS       = 8'h0C;
  localparam logic [7:0] FAULT_WORD_OFS = 8'h10;
  localparam logic [7:0] LIVE_OFS       = 8'h14;

  // Field positions in the control and fault words.
  localparam int STOP_ON_FAULT_POS = 6;
  localparam int BLANK_LSB         = 6;
  localparam int BLANK_W           = 4;
  localparam int THRESH_LSB        = 0;
  localparam int THRESH_W          = 6;
  localparam int COMMON_FAULT_BIT  = 15;
  localparam int POR_BIT           = 14;
  localparam int REG_UV_BIT        = 13;
  localparam int TEMP_WARN_BIT     = 11;
  localparam int OVERTEMP_BIT      = 10;
  localparam int BOOT_LSB          = 7;
  localparam int SHORT_LSB         = 0;

  // Reset values.
  localparam logic [15:0] RUN_RST       = 16'h0000;
  localparam logic [15:0] CFG0_RST      = 16'h0214;
  localparam logic [15:0] CFG1_RST      = 16'h03E0;
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] FAULT_POR_VAL = 16'hC000;

  // Timing.
  localparam int CLK_MHZ          = 50;
  localparam int BLANK_UNIT_NS    = 400;
  localparam int BLANK_UNIT_CYC   = (BLANK_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int BOOT_TIMEOUT_US  = 20;
  localparam int BOOT_TIMEOUT_CYC = BOOT_TIMEOUT_US * CLK_MHZ;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {BS_IDLE, BS_CHARGE, BS_ON} boot_st_t;
endpackage

// >>> testbench/bridge_model.sv
// Purpose: Bootstrap capacitors of the external bridge, one per phase.
// Assumes: A capacitor is charged one cycle after its low side turns on.
// Notes:   A dead capacitor never charges, so a charge cycle times out.
`timescale 1ns/100ps
module bridge_model
(
  // Clock.
  input  wire logic       aclk,
  // Bridge drive and test controls.
  input  wire logic [2:0] ls_gate,
  input  wire logic [2:0] dead,
  // Monitor result, high when charged.
  output logic      [2:0] boot_ok_raw
);
  initial boot_ok_raw = 3'h0;

  // Charging needs the low side on; a dead capacitor reads flat at once.
  always @(posedge aclk)
  begin
    boot_ok_raw <= (boot_ok_raw | (ls_gate & ~dead)) & ~dead;
  end
endmodule

// >>> testbench/gate_driver_fault_monitor_tb.sv
// Purpose: Self-checking bench for the gate-driver fault monitor.
// Assumes: Bootstrap timeout shortened to 20 cycles.
// Notes:   Comparator levels settle on the pin within four edges.
`timescale 1ns/100ps
module gate_driver_fault_monitor_tb;
  import fault_mon_pkg::*;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, tw = 0, ot = 0, guv = 0, luv = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 4'h3;
  logic [2:0]  hs_req = 0, ls_req = 0, dead = 0;
  logic [5:0]  vds = 0;
  logic        ext_rst_n = 1;
  logic [15:0] v;
  logic        seen;
  wire logic   awready, wready, bvalid, arready, rvalid, pin_n;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  boot_ok, hs_gate, ls_gate;
  wire logic [5:0]  thr;
  int          fail_count = 0, checked = 0, cyc = 0;

  gate_driver_fault_monitor #(.BOOT_TO_CYC(20)) DUT
  (
    .aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .temp_warn_raw(tw), .overtemp_raw(ot), .gate_supply_uv_raw(guv),
    .logic_uv_raw(luv), .boot_ok_raw(boot_ok), .vds_high_raw(vds),
    .hs_req, .ls_req, .hs_gate, .ls_gate,
    .active_low_reset_input(ext_rst_n),
    .fault_output_pin_n(pin_n), .drain_source_threshold_code(thr)
  );
  bridge_model PM (.aclk, .ls_gate, .dead, .boot_ok_raw(boot_ok));

  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Expected fault word: any fault bit also raises the common flag.
  function automatic logic [15:0] fw(input logic [15:0] b);
    return (b == 16'h0000) ? b : (b | 16'h8000);
  endfunction

  task automatic close_out();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk(bresp, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {16'h0000, e});
    chk(rresp, er);
  endtask

  // A hang counts as a failure and ends the run.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    void'($urandom(32'h8539));
    repeat (20) @(posedge aclk);
    chk(pin_n, 0);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(pin_n, 1);
    chk(thr, 32'h20);
    rd(CFG0_OFS, CFG0_RST, RESP_OKAY);
    rd(FAULT_WORD_OFS, FAULT_POR_VAL, RESP_OKAY);
    rd(8'h18, 16'h0000, RESP_SLVERR);
    wr(FAULT_WORD_OFS, 16'h0000);
    rd(FAULT_WORD_OFS, 16'h0000, RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 4) ? 16'h003F : (16'($urandom) & 16'h003F);
      wr(CFG1_OFS, v);
      chk(thr, v);
    end
    $display("done reset and threshold");
    tw <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(pin_n, 0);
    tw <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(pin_n, 1);
    rd(FAULT_WORD_OFS, fw(16'h0800), RESP_OKAY);
    $display("done warning");
    ls_req <= 3'h7;
    for (int s = 0; s < 2; s++)
    begin
      wr(RUN_OFS, s ? 16'h0040 : 16'h0000);
      ot <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(pin_n, 0);
      chk(ls_gate, s ? 3'h0 : 3'h7);
      ot <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(pin_n, 1);
      rd(FAULT_WORD_OFS, fw(16'h0400), RESP_OKAY);
    end
    $display("done overtemperature");
    wr(MASK_OFS, 16'hFFFF);
    tw <= 1'b1;
    ot <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({pin_n, ls_gate}, 4'hF);
    guv <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({pin_n, ls_gate}, 4'h0);
    {guv, tw, ot} <= 3'h0;
    repeat (5) @(posedge aclk);
    chk({pin_n, ls_gate}, 4'hF);
    rd(FAULT_WORD_OFS, fw(16'h2000), RESP_OKAY);
    $display("done mask and gate supply");
    wr(MASK_OFS, 16'h0000);
    ls_req <= 3'h0;
    // Pass 0 starts from flat capacitors; pass 1 drains A while it is on.
    for (int p = 0; p < 2; p++)
    begin
      dead <= p ? 3'h1 : 3'h7;
      repeat (3) @(posedge aclk);
      dead <= 3'h0;
      hs_req <= 3'h1;
      seen = 1'b0;
      repeat (30)
      begin
        @(posedge aclk);
        if (ls_gate[0])
          seen = 1'b1;
      end
      chk({seen, hs_gate}, 4'h9);
    end
    dead <= 3'h2;
    hs_req <= 3'h2;
    repeat (40) @(posedge aclk);
    chk({pin_n, hs_gate}, 4'h0);
    hs_req <= 3'h0;
    repeat (5) @(posedge aclk);
    chk(pin_n, 0);
    rd(FAULT_WORD_OFS, fw(16'h0100), RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk(pin_n, 1);
    $display("done bootstrap");
    // Low-side A short with stop-on-fault; default blanking is 160 cycles.
    wr(RUN_OFS, 16'h0040);
    ls_req <= 3'h1;
    vds <= 6'h08;
    repeat (100) @(posedge aclk);
    chk(pin_n, 1);
    repeat (100) @(posedge aclk);
    chk({pin_n, ls_gate}, 4'h0);
    vds <= 6'h00;
    repeat (5) @(posedge aclk);
    chk(pin_n, 0);
    ext_rst_n <= 1'b0;
    @(posedge aclk);
    ext_rst_n <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({pin_n, ls_gate}, 4'h9);
    rd(FAULT_WORD_OFS, fw(16'h0008), RESP_OKAY);
    $display("done short");
    dead <= 3'h0;
    ls_req <= 3'h7;
    wr(CFG1_OFS, 16'h0011);
    luv <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({pin_n, ls_gate}, 4'h0);
    luv <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(thr, 32'h20);
    rd(FAULT_WORD_OFS, FAULT_POR_VAL, RESP_OKAY);
    chk(pin_n, 1);
    $display("done brown-out");
    close_out();
  end
endmodule
